//--- bench/rcd_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rcd_core_chk (
  // Clock
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Decode
  input wire logic [15:0] insn,
  input wire logic src_rd,
  input wire logic [3:0] src_module,
  input wire logic [3:0] src_index,
  input wire logic dst_wr,
  input wire logic [3:0] dst_module,
  input wire logic [4:0] dst_index,
  input wire logic [15:0] dst_wdata,
  // Flow and stack
  input wire logic branch,
  input wire logic call,
  input wire logic sub_return,
  input wire logic irq_take,
  input wire logic [15:0] branch_addr,
  input wire logic [15:0] fetch_addr,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [15:0] stack_top,
  input wire logic [3:0] stack_index
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Prefix target and quiet flow
  wire logic destination_prefix = insn[11:8] == 4'hb && insn[14:12] == 3'h0;
  wire logic quiet = !call && !branch && !sub_return && !irq_take;
  sequence s_pfx; clk_en && destination_prefix && !insn[15]; endsequence
  sequence s_push; clk_en && stack_push && !stack_pop && quiet; endsequence
  property p_src; src_module == insn[3:0] && src_index == insn[7:4]; endproperty
  property p_fmt; clk_en |-> src_rd == insn[15]; endproperty
  property p_dst; dst_module == insn[11:8] && dst_index[2:0] == insn[14:12]; endproperty
  property p_pfx; s_pfx |=> dst_index[4:3] == $past(insn[1:0]); endproperty
  property p_wr; clk_en |-> dst_wr == !destination_prefix; endproperty
  property p_rst; $past(reset) |-> stack_index == 4'hf; endproperty
  property p_push;
    s_push |=> stack_index == $past(stack_index) + 4'h1 && stack_top == $past(dst_wdata);
  endproperty
  property p_pop;
    clk_en && stack_pop && !stack_push && quiet |=> stack_index == $past(stack_index) - 4'h1;
  endproperty
  property p_call;
    clk_en && call && !stack_push && !irq_take |=>
      fetch_addr == $past(branch_addr) && stack_top == $past(fetch_addr) + 16'h1;
  endproperty
  property p_ret;
    clk_en && sub_return && !call && !branch && !stack_push && !irq_take |=>
      fetch_addr == $past(stack_top);
  endproperty
  a_src: assert property (p_src) else $error("source fields");
  a_fmt: assert property (p_fmt) else $error("source format");
  a_dst: assert property (p_dst) else $error("destination fields");
  a_pfx: assert property (p_pfx) else $error("prefix bits");
  a_wr: assert property (p_wr) else $error("write strobe");
  a_rst: assert property (p_rst) else $error("index after reset");
  a_push: assert property (p_push) else $error("push");
  a_pop: assert property (p_pop) else $error("pop");
  a_call: assert property (p_call) else $error("call");
  a_ret: assert property (p_ret) else $error("return");
endmodule // rcd_core_chk
bind rcd_core rcd_core_chk u_chk (
  .ref_clk, .reset, .clk_en, .insn, .src_rd, .src_module, .src_index, .dst_wr,
  .dst_module, .dst_index, .dst_wdata, .branch, .call, .sub_return, .branch_addr,
  .fetch_addr, .stack_push, .stack_pop, .stack_top, .stack_index, .irq_take
);
`default_nettype wire

//--- bench/rcd_reg_model.sv
`timescale 1ns/100ps
`default_nettype none
module rcd_reg_model (
  // Source read port
  input wire logic src_rd,
  input wire logic [3:0] src_module,
  input wire logic [3:0] src_index,
  output logic [15:0] src_rdata
);
  // Value tied to the register picked
  wire logic [15:0] pat = {src_index, src_module, 8'h5a};
  // Inverted when nothing is read
  assign src_rdata = src_rd ? pat : ~pat;
endmodule // rcd_reg_model
`default_nettype wire

//--- bench/tb_risc_core_decode_and_stack.sv
`timescale 1ns/100ps
`default_nettype none
module tb_risc_core_decode_and_stack;
  logic ref_clk, reset, clk_en, branch, call, sub_return, irq_take, stack_push, stack_pop;
  logic stack_fetch_alt, lock_en, key_word_valid, map_data_in_prog, map_prog_in_data;
  logic map_unified, interrupt_exit;
  logic [15:0] insn, branch_addr, irq_vector, data_addr, key_word, stored_key_word, pc, v, r;
  logic [2:0] ptr_load, ptr_access, ptr_auto_en, ptr_auto_dec;
  wire logic src_rd, dst_wr, fetch_from_data, fetch_from_urom, data_to_prog;
  wire logic code_unlocked, code_read_deny;
  wire logic [15:0] src_rdata, fetch_addr, dst_wdata, stack_top, data_phys_addr;
  wire logic [3:0] src_module, src_index, dst_module, stack_index;
  wire logic [4:0] dst_index;
  wire logic [47:0] ptr_values;
  logic [15:0] q[$];
  int miscompares = 0;
  int num_checks = 0;
  rcd_core dut (.ref_clk, .reset, .clk_en, .insn, .fetch_addr, .fetch_from_data,
    .fetch_from_urom, .src_rdata, .src_rd, .src_module, .src_index, .dst_wr, .dst_module,
    .dst_index, .dst_wdata, .branch, .branch_addr, .call, .sub_return, .irq_take,
    .irq_vector, .interrupt_exit, .stack_push, .stack_pop, .stack_fetch_alt,
    .stack_top, .stack_index,
    .ptr_load, .ptr_access, .ptr_auto_en, .ptr_auto_dec, .ptr_values, .map_data_in_prog,
    .map_prog_in_data, .map_unified, .data_addr, .data_to_prog, .data_phys_addr, .lock_en,
    .key_word_valid, .key_word, .stored_key_word, .code_unlocked, .code_read_deny);
  rcd_reg_model u_regs (.src_rd, .src_module, .src_index, .src_rdata);
  // Expected write data: zero-extended byte or register value
  function automatic logic [15:0] wexp(input logic [15:0] i);
    return i[15] ? {i[7:0], 8'h5a} : {8'h00, i[7:0]};
  endfunction
  // Expected fetch address under the mapping modes
  function automatic logic [15:0] fexp(input logic [15:0] p);
    if (map_unified && p >= rcd_pkg::UNI_DATA_BASE) begin
      return p - rcd_pkg::UNI_DATA_BASE;
    end
    if (map_unified && p >= rcd_pkg::UNI_UROM_BASE) begin
      return p - rcd_pkg::UNI_UROM_BASE;
    end
    if (map_data_in_prog && p >= rcd_pkg::DATA_IN_PROG_BASE) begin
      return p - rcd_pkg::DATA_IN_PROG_BASE;
    end
    return p;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One instruction, from falling edge to falling edge
  task automatic cyc(input logic [15:0] i);
    insn = i;
    pc = pc + 16'h1;
    #1;
    chk("wdata", wexp(i), dst_wdata);
    @(negedge ref_clk);
    chk("pc", fexp(pc), fetch_addr);
  endtask
  task automatic jump(input logic [15:0] t);
    branch = 1'b1;
    branch_addr = t;
    pc = t - 16'h1;
    cyc(16'h0100);
    branch = 1'b0;
  endtask
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Watchdog, run is well under a thousand cycles
  initial begin
    #20us;
    miscompares++;
    results();
  end
  // Tests
  initial begin
    {branch, call, sub_return, interrupt_exit, irq_take} = '0;
    {stack_push, stack_pop, stack_fetch_alt} = '0;
    {lock_en, key_word_valid, map_data_in_prog, map_prog_in_data, map_unified} = '0;
    {insn, branch_addr, irq_vector, key_word, stored_key_word} = '0;
    {ptr_load, ptr_access, ptr_auto_en, ptr_auto_dec} = '0;
    reset = 1'b1;
    clk_en = 1'b1;
    data_addr = 16'h8005;
    pc = 16'h0;
    v = 16'($urandom(54));
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    chk("index", 16'h000f, {12'h0, stack_index});
    chk("pc0", 16'h0, fetch_addr);
    chk("d2p", 16'h0, {15'h0, data_to_prog});
    $display("reset done");
    repeat (24) begin
      v = 16'($urandom);
      v[11] = 1'b0;
      insn = v;
      #1;
      chk("src", {8'h0, v[7:0]}, {8'h0, src_index, src_module});
      chk("src_rd", {15'h0, v[15]}, {15'h0, src_rd});
      chk("dst", {9'h0, v[14:8]}, {7'h0, dst_index, dst_module});
      cyc(v);
    end
    $display("decode done");
    for (int k = 0; k < 4; k++) begin
      cyc(16'h0b00 | 16'(k));
      chk("pfx_wr", 16'h0, {15'h0, dst_wr});
      insn = 16'h1900;
      #1;
      chk("pfx_dst", {11'h0, 2'(k), 3'h1}, {11'h0, dst_index});
      cyc(16'h1900);
      chk("after", 16'h0001, {11'h0, dst_index});
    end
    $display("prefix done");
    repeat (17) begin
      v = 16'($urandom) & 16'h00ff;
      q.push_front(v);
      stack_push = 1'b1;
      cyc(16'h0100 | v);
      chk("push_top", v, stack_top);
    end
    stack_push = 1'b0;
    chk("wrap_up", 16'h0, {12'h0, stack_index});
    for (int k = 0; k < 16; k++) begin
      chk("pop_top", q[k], stack_top);
      stack_pop = 1'b1;
      cyc(16'h0100);
    end
    stack_pop = 1'b0;
    chk("wrap_dn", 16'h0, {12'h0, stack_index});
    v = 16'($urandom) & 16'h3fff;
    r = pc + 16'h1;
    call = 1'b1;
    branch_addr = v;
    pc = v - 16'h1;
    cyc(16'h0100);
    call = 1'b0;
    chk("ret_addr", r, stack_top);
    sub_return = 1'b1;
    pc = r - 16'h1;
    cyc(16'h0100);
    sub_return = 1'b0;
    // Interrupt entry and exit through the stack
    v = 16'($urandom) & 16'h3fff;
    r = pc + 16'h1;
    irq_take = 1'b1;
    irq_vector = v;
    pc = v - 16'h1;
    cyc(16'h0100);
    irq_take = 1'b0;
    chk("irq_ret", r, stack_top);
    interrupt_exit = 1'b1;
    pc = r - 16'h1;
    cyc(16'h0100);
    interrupt_exit = 1'b0;
    // Alternate fetch pops like a plain pop
    stack_push = 1'b1;
    cyc(16'h0142);
    stack_push = 1'b0;
    r = {12'h0, stack_index};
    chk("alt_top", 16'h0042, stack_top);
    stack_fetch_alt = 1'b1;
    cyc(16'h0100);
    stack_fetch_alt = 1'b0;
    chk("alt_idx", {12'h0, 4'(r[3:0] - 4'h1)}, {12'h0, stack_index});
    // Frozen cycle: nothing moves while the enable is low
    clk_en = 1'b0;
    stack_push = 1'b1;
    r = {12'h0, stack_index};
    insn = 16'h0155;
    @(negedge ref_clk);
    chk("hold_pc", fexp(pc), fetch_addr);
    chk("hold_idx", r, {12'h0, stack_index});
    chk("hold_wr", 16'h0, {15'h0, dst_wr});
    clk_en = 1'b1;
    stack_push = 1'b0;
    $display("stack done");
    map_data_in_prog = 1'b1;
    jump(16'ha000);
    chk("from_data", 16'h1, {15'h0, fetch_from_data});
    map_data_in_prog = 1'b0;
    map_unified = 1'b1;
    jump(16'h8000);
    chk("from_urom", 16'h1, {15'h0, fetch_from_urom});
    chk("d2p_uni", 16'h1, {15'h0, data_to_prog});
    map_unified = 1'b0;
    map_prog_in_data = 1'b1;
    #1;
    chk("d2p", 16'h1, {15'h0, data_to_prog});
    chk("dphys", data_addr - rcd_pkg::PROG_IN_DATA_BASE, data_phys_addr);
    map_prog_in_data = 1'b0;
    jump(16'h0000);
    $display("map done");
    for (int g = 0; g < 3; g++) begin
      v = 16'($urandom) & 16'h00ff;
      ptr_load[g] = 1'b1;
      cyc(v);
      ptr_load[g] = 1'b0;
      chk("ptr_ld", v, ptr_values[16*g +: 16]);
      ptr_access[g] = 1'b1;
      ptr_auto_en[g] = 1'b1;
      cyc(16'h0100);
      chk("ptr_inc", v + 16'h1, ptr_values[16*g +: 16]);
      ptr_auto_dec[g] = 1'b1;
      cyc(16'h0100);
      chk("ptr_dec", v, ptr_values[16*g +: 16]);
      {ptr_access[g], ptr_auto_en[g], ptr_auto_dec[g]} = 3'h0;
    end
    $display("pointer done");
    lock_en = 1'b1;
    #1;
    chk("deny", 16'h1, {15'h0, code_read_deny});
    key_word_valid = 1'b1;
    for (int k = 0; k < 32; k++) begin
      stored_key_word = 16'($urandom);
      key_word = (k == 3) ? ~stored_key_word : stored_key_word;
      cyc(16'h0100);
      if (k == 15) chk("bad_key", 16'h0, {15'h0, code_unlocked});
    end
    key_word_valid = 1'b0;
    chk("unlock", 16'h1, {15'h0, code_unlocked});
    chk("open", 16'h0, {15'h0, code_read_deny});
    $display("lock done");
    results();
  end
endmodule // tb_risc_core_decode_and_stack
`default_nettype wire

//--- hw/rcd_core.sv
`timescale 1ns/100ps
`default_nettype none
module rcd_core #(
  parameter int NPTR = 3
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Instruction fetch
  input wire logic [rcd_pkg::INSN_W-1:0] insn,
  output logic [rcd_pkg::ADDR_W-1:0] fetch_addr,
  output logic fetch_from_data,
  output logic fetch_from_urom,
  // Source read port
  input wire logic [rcd_pkg::INSN_W-1:0] src_rdata,
  output logic src_rd,
  output logic [rcd_pkg::MOD_W-1:0] src_module,
  output logic [rcd_pkg::SIDX_W-1:0] src_index,
  // Destination write port
  output logic dst_wr,
  output logic [rcd_pkg::MOD_W-1:0] dst_module,
  output logic [rcd_pkg::DIDX_FULL_W-1:0] dst_index,
  output logic [rcd_pkg::INSN_W-1:0] dst_wdata,
  // Control flow requests from side-effect logic
  input wire logic branch,
  input wire logic [rcd_pkg::ADDR_W-1:0] branch_addr,
  input wire logic call,
  input wire logic sub_return,
  input wire logic interrupt_exit,
  input wire logic irq_take,
  input wire logic [rcd_pkg::ADDR_W-1:0] irq_vector,
  // Stack data ops
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic stack_fetch_alt,
  output logic [rcd_pkg::STK_W-1:0] stack_top,
  output logic [rcd_pkg::STK_IDX_W-1:0] stack_index,
  // Data pointers
  input wire logic [NPTR-1:0] ptr_load,
  input wire logic [NPTR-1:0] ptr_access,
  input wire logic [NPTR-1:0] ptr_auto_en,
  input wire logic [NPTR-1:0] ptr_auto_dec,
  output logic [NPTR*rcd_pkg::ADDR_W-1:0] ptr_values,
  // Memory map control
  input wire logic map_data_in_prog,
  input wire logic map_prog_in_data,
  input wire logic map_unified,
  input wire logic [rcd_pkg::ADDR_W-1:0] data_addr,
  output logic data_to_prog,
  output logic [rcd_pkg::ADDR_W-1:0] data_phys_addr,
  // Code protection
  input wire logic lock_en,
  input wire logic key_word_valid,
  input wire logic [rcd_pkg::INSN_W-1:0] key_word,
  input wire logic [rcd_pkg::INSN_W-1:0] stored_key_word,
  output logic code_unlocked,
  output logic code_read_deny
);
  rcd_pkg::rcd_state_t state_r;
  logic [rcd_pkg::ADDR_W-1:0] pc_r;
  logic [rcd_pkg::ADDR_W-1:0] pc_nxt;
  logic [rcd_pkg::PFX_DST_W-1:0] pfx_r;
  logic fmt;
  logic [rcd_pkg::SRC_W-1:0] src_field;
  logic [rcd_pkg::DST_W-1:0] dst_field;
  logic pfx_write;
  logic push_any;
  logic pop_any;
  logic [rcd_pkg::STK_W-1:0] push_val;
  logic [rcd_pkg::STK_W-1:0] stk_top;
  logic [4:0] key_cnt_r;
  logic key_ok_r;
  logic unlocked_r;
  logic [rcd_pkg::ADDR_W-1:0] ptr_load_val;
  logic [rcd_pkg::PFX_DST_W-1:0] dst_ext;
  logic pop_gated;
  logic key_take;
  logic key_match;
  logic key_last;

  // Field extraction, one word per instruction
  assign fmt = insn[rcd_pkg::FMT_BIT];
  assign src_field = insn[rcd_pkg::SRC_LSB +: rcd_pkg::SRC_W];
  assign dst_field = insn[rcd_pkg::DST_LSB +: rcd_pkg::DST_W];

  // Source: register selector or immediate
  assign src_rd = clk_en && (fmt == rcd_pkg::FMT_REG);
  assign src_module = src_field[rcd_pkg::MOD_W-1:0];
  assign src_index = src_field[rcd_pkg::SRC_W-1:rcd_pkg::MOD_W];

  // Destination module and prefix target decode
  assign dst_module = dst_field[rcd_pkg::MOD_W-1:0];
  assign pfx_write = (dst_module == rcd_pkg::PFX_MOD) &&
    (dst_field[rcd_pkg::DST_W-1:rcd_pkg::MOD_W] == rcd_pkg::PFX_IDX);
  assign dst_wr = clk_en && !pfx_write;

  // Upper index bits only in the cycle right after a prefix write
  always_comb begin
    case (state_r)
      rcd_pkg::RCD_ST_PFX: begin
        dst_ext = pfx_r;
      end
      rcd_pkg::RCD_ST_EXEC: begin
        dst_ext = '0;
      end
      default: begin
        dst_ext = '0;
      end
    endcase
  end
  assign dst_index = {dst_ext, dst_field[rcd_pkg::DST_W-1:rcd_pkg::MOD_W]};

  // Transfer data: immediate zero-extended or register value
  always_comb begin
    if (fmt == rcd_pkg::FMT_IMM) begin
      dst_wdata = {8'h00, src_field};
    end else begin
      dst_wdata = src_rdata;
    end
  end

  // Prefix value held for exactly the next instruction
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pfx_r <= '0;
    end else if (clk_en) begin
      if (pfx_write) begin
        pfx_r <= dst_wdata[rcd_pkg::PFX_DST_W-1:0];
      end else begin
        pfx_r <= '0;
      end
    end
  end

  // Execution state, a prefix write costs one cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= rcd_pkg::RCD_ST_EXEC;
    end else if (clk_en) begin
      if (pfx_write) begin
        state_r <= rcd_pkg::RCD_ST_PFX;
      end else begin
        state_r <= rcd_pkg::RCD_ST_EXEC;
      end
    end
  end

  // Stack operations
  assign push_any = call || irq_take || stack_push;
  assign pop_any = sub_return || interrupt_exit || stack_pop || stack_fetch_alt;
  // Push wins over a pop in the same cycle
  assign pop_gated = pop_any && !push_any;

  // Return address for call and interrupt, else the moved value
  always_comb begin
    if (call || irq_take) begin
      push_val = pc_r + 16'h0001;
    end else begin
      push_val = dst_wdata;
    end
  end

  rcd_stack u_stack (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .push(push_any),
    .pop(pop_gated),
    .push_data(push_val),
    .top_data(stk_top),
    .stack_index(stack_index)
  );
  assign stack_top = stk_top;

  // Next program counter
  always_comb begin
    case (1'b1)
      irq_take: pc_nxt = irq_vector;
      call, branch: pc_nxt = branch_addr;
      sub_return, interrupt_exit: pc_nxt = stk_top;
      default: pc_nxt = pc_r + 16'h0001;
    endcase
  end

  // Single-cycle fetch and execute
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_r <= '0;
    end else if (clk_en) begin
      pc_r <= pc_nxt;
    end
  end

  // Fetch address mapping
  always_comb begin
    fetch_addr = pc_r;
    fetch_from_data = 1'b0;
    fetch_from_urom = 1'b0;
    if (map_unified) begin
      fetch_from_urom = pc_r >= rcd_pkg::UNI_UROM_BASE && pc_r < rcd_pkg::UNI_DATA_BASE;
      fetch_from_data = pc_r >= rcd_pkg::UNI_DATA_BASE;
    end else if (map_data_in_prog) begin
      fetch_from_data = pc_r >= rcd_pkg::DATA_IN_PROG_BASE;
    end
    if (fetch_from_data) begin
      fetch_addr = pc_r - rcd_pkg::DATA_IN_PROG_BASE;
    end else if (fetch_from_urom) begin
      fetch_addr = pc_r - rcd_pkg::UNI_UROM_BASE;
    end
  end

  // Data address mapping, Harvard by default
  always_comb begin
    data_to_prog = 1'b0;
    data_phys_addr = data_addr;
    if (map_unified) begin
      data_to_prog = data_addr < rcd_pkg::UNI_DATA_BASE;
      data_phys_addr = data_to_prog ? data_addr : data_addr - rcd_pkg::UNI_DATA_BASE;
    end else if (map_prog_in_data && data_addr >= rcd_pkg::PROG_IN_DATA_BASE) begin
      data_to_prog = 1'b1;
      data_phys_addr = data_addr - rcd_pkg::PROG_IN_DATA_BASE;
    end
  end

  // Data pointers, one per channel
  assign ptr_load_val = dst_wdata;
  for (genvar g = 0; g < NPTR; g++) begin : g_ptr
    rcd_dptr u_ptr (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .load(ptr_load[g]),
      .load_val(ptr_load_val),
      .access(ptr_access[g]),
      .auto_en(ptr_auto_en[g]),
      .auto_dec(ptr_auto_dec[g]),
      .ptr(ptr_values[g*rcd_pkg::ADDR_W +: rcd_pkg::ADDR_W])
    );
  end

  // Key word match and end of a sixteen-word group
  assign key_take = clk_en && key_word_valid && !unlocked_r;
  assign key_match = key_word == stored_key_word;
  assign key_last = key_cnt_r == 5'(rcd_pkg::KEY_WORDS - 1);

  // Word counter, restarts after each group
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      key_cnt_r <= '0;
    end else if (key_take) begin
      if (key_last) begin
        key_cnt_r <= '0;
      end else begin
        key_cnt_r <= key_cnt_r + 5'h01;
      end
    end
  end

  // Running match over the group
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      key_ok_r <= 1'b1;
    end else if (key_take) begin
      if (key_last) begin
        key_ok_r <= 1'b1;
      end else begin
        key_ok_r <= key_ok_r && key_match;
      end
    end
  end

  // Unlock once a whole group matched, ignore words after that
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      unlocked_r <= 1'b0;
    end else if (key_take && key_last) begin
      unlocked_r <= key_ok_r && key_match;
    end
  end

  assign code_unlocked = unlocked_r;
  assign code_read_deny = lock_en && !unlocked_r;
endmodule // rcd_core
`default_nettype wire

//--- hw/rcd_dptr.sv
`timescale 1ns/100ps
`default_nettype none
module rcd_dptr #(
  parameter int AW = rcd_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Control
  input wire logic load,
  input wire logic [AW-1:0] load_val,
  input wire logic access,
  input wire logic auto_en,
  input wire logic auto_dec,
  // Pointer
  output logic [AW-1:0] ptr
);
  logic [AW-1:0] ptr_r;

  // Load, then step after each access when enabled
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr_r <= '0;
    end else if (clk_en) begin
      if (load) begin
        ptr_r <= load_val;
      end else if (access && auto_en) begin
        ptr_r <= auto_dec ? ptr_r - 1'b1 : ptr_r + 1'b1;
      end
    end
  end

  assign ptr = ptr_r;
endmodule // rcd_dptr
`default_nettype wire

//--- hw/rcd_pkg.sv
package rcd_pkg;
  // Instruction word layout
  localparam int INSN_W = 16;
  localparam int FMT_BIT = 15;
  localparam int SRC_LSB = 0;
  localparam int SRC_W = 8;
  localparam int DST_LSB = 8;
  localparam int DST_W = 7;
  localparam int MOD_W = 4;
  localparam int SIDX_W = 4;
  localparam int DIDX_W = 3;
  localparam int PFX_DST_W = 2;
  localparam int DIDX_FULL_W = 5;
  // Source format codes
  localparam logic FMT_IMM = 1'b0;
  localparam logic FMT_REG = 1'b1;
  // Prefix register location in the destination space
  localparam logic [3:0] PFX_MOD = 4'hb;
  localparam logic [2:0] PFX_IDX = 3'h0;
  // Stack geometry
  localparam int STK_DEPTH = 16;
  localparam int STK_W = 16;
  localparam int STK_IDX_W = 4;
  localparam logic [3:0] STK_TOP = 4'hf;
  // Memory sizes in words, address width and key length
  localparam int PROG_WORDS = 32768;
  localparam int DATA_WORDS = 1024;
  localparam int UROM_WORDS = 2048;
  localparam int ADDR_W = 16;
  localparam int KEY_WORDS = 16;
  // Unified map bases, then data-in-program and program-in-data bases
  localparam logic [15:0] UNI_PROG_BASE = 16'h0000;
  localparam logic [15:0] UNI_UROM_BASE = 16'h8000;
  localparam logic [15:0] UNI_DATA_BASE = 16'ha000;
  localparam logic [15:0] DATA_IN_PROG_BASE = 16'ha000;
  localparam logic [15:0] PROG_IN_DATA_BASE = 16'h8000;
  // Stack operation kinds
  typedef enum logic [2:0] {
    RCD_STK_NONE = 3'h0,
    RCD_STK_PUSH = 3'h1,
    RCD_STK_POP = 3'h2
  } rcd_stk_op_t;
  // Execution states
  typedef enum logic [1:0] {
    RCD_ST_EXEC = 2'h1,
    RCD_ST_PFX = 2'h2
  } rcd_state_t;
endpackage

//--- hw/rcd_stack.sv
`timescale 1ns/100ps
`default_nettype none
module rcd_stack #(
  parameter int DEPTH = rcd_pkg::STK_DEPTH,
  parameter int WIDTH = rcd_pkg::STK_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Operation
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  // State
  output logic [WIDTH-1:0] top_data,
  output logic [rcd_pkg::STK_IDX_W-1:0] stack_index
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [rcd_pkg::STK_IDX_W-1:0] stack_index_r;
  logic [rcd_pkg::STK_IDX_W-1:0] inc_idx;

  // Wrapping increment, no error flag
  assign inc_idx = stack_index_r + 4'h1;

  // Index update
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stack_index_r <= rcd_pkg::STK_TOP;
    end else if (clk_en) begin
      if (push) begin
        stack_index_r <= inc_idx;
      end else if (pop) begin
        stack_index_r <= stack_index_r - 4'h1;
      end
    end
  end

  // Entry write at incremented index
  always_ff @(posedge ref_clk) begin
    if (clk_en && push && !reset) begin
      mem[inc_idx] <= push_data;
    end
  end

  // Read current top before decrement
  assign top_data = mem[stack_index_r];
  assign stack_index = stack_index_r;
endmodule // rcd_stack
`default_nettype wire
